/* File: src/power_mode_map.svh */
// register offsets, field positions, reset values and timing counts for the
// low-power mode controller; included by the design file and the bench
`ifndef POWER_MODE_MAP_SVH
`define POWER_MODE_MAP_SVH

// register offsets (word index on the plain register port)
`define REG_MODE_CTRL 4'h0
`define REG_CLK_GATE 4'h1
`define REG_STANDBY_PULL 4'h2
`define REG_WAKE_CFG 4'h3
`define REG_CLK_MON 4'h4
`define REG_STATUS 4'h5
`define REG_WAKE_FLAGS 4'h6

// mode control fields
`define MODE_SEL_LO 0
`define MODE_SEL_HI 2
`define SRAM_RETAIN_BIT 3
`define CAL_KEEP_BIT 4
`define LP_RUN_BIT 5
`define CHARGE_EN_BIT 6
`define SLOW_OUT_EN_BIT 7
`define SLOW_OUT_SEL_BIT 8

// clock monitor fields
`define MON_EN_BIT 0
`define MON_IRQ_EN_BIT 1
`define MON_FAST_FAIL_BIT 2
`define MON_SLOW_FAIL_BIT 3

// clock gate fields
`define GATE_CORE_BIT 0
`define GATE_MEM_BIT 1

// wake configuration fields
`define WAKE_POL_BIT 0

// mode select encodings
`define SEL_SLEEP 3'h0
`define SEL_STOP0 3'h1
`define SEL_STOP1 3'h2
`define SEL_STANDBY 3'h3
`define SEL_SHUTDOWN 3'h4

// reset values
`define MODE_CTRL_RST 9'h000
`define CLK_GATE_RST 32'hffffffff
`define PULL_RST 32'h00000000
`define DEEP_KEEP_MASK 9'h018

// processor clock limit in low-power run
`define SYS_CLK_MHZ 250
`define LP_CPU_MHZ 2
`define LP_DIV_COUNT 8'h7d

`endif

/* File: src/power_mode_pkg.sv */
// types for the low-power mode controller
// assumes power_mode_map.svh sits in the include path
package power_mode_pkg;

  // one-hot power mode states
  typedef enum logic [7:0] {
    ST_RUN = 8'h01,
    ST_SLEEP = 8'h02,
    ST_LP_RUN = 8'h04,
    ST_LP_SLEEP = 8'h08,
    ST_STOP0 = 8'h10,
    ST_STOP1 = 8'h20,
    ST_STANDBY = 8'h40,
    ST_SHUTDOWN = 8'h80
  } power_state_t;

  // power and oscillator enables driven to the analog side
  typedef struct packed {
    logic main_regulator_on;
    logic low_power_regulator_on;
    logic lpr_sram_only;
    logic pll_on;
    logic internal_fast_oscillator_on;
    logic external_fast_oscillator_on;
    logic internal_slow_oscillator_on;
    logic external_slow_oscillator_on;
    logic supply_on_off_reset_on;
    logic brownout_detection_on;
  } power_ctrl_t;

  // wake sources arriving from the rest of the chip
  typedef struct packed {
    logic ext_reset;
    logic watchdog_reset;
    logic wakeup_pin;
    logic cal_alarm;
    logic cal_periodic;
    logic cal_timestamp;
    logic cal_tamper;
    logic periph_irq;
  } wake_src_t;

endpackage

/* File: src/low_power_mode_controller.sv */
// low-power mode controller: selects regulators, stops clocks and
// oscillators per mode, handles wake, reset pad control, backup supply
// switch, clock failure switchover and slow clock output.
// assumes all inputs synchronous to clk; analog blocks obey the enables.
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
`include "power_mode_map.svh"

module low_power_mode_controller
  import power_mode_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // processor handshake
  input wire logic wait_instr,
  input wire logic internal_reset,
  input wire logic periph_fast_osc_req,
  // wake and supply inputs
  input wire wake_src_t wake_src,
  input wire logic main_supply_valid,
  input wire logic battery_valid,
  input wire logic fast_xtal_fail,
  input wire logic slow_xtal_fail,
  input wire logic slow_clk_in,
  // analog control outputs
  output power_ctrl_t power_ctrl,
  output logic [7:0] mode_onehot,
  output logic cpu_clk_en,
  output logic cpu_clk_slow_en,
  output logic core_clk_en,
  output logic [31:0] periph_clk_en,
  output logic mem_clk_en,
  output logic sram_retain,
  output logic regs_lost,
  output logic [31:0] pad_pull_up,
  output logic [31:0] pad_pull_down,
  output logic schmitt_en,
  output logic reset_pullup_en,
  output logic backup_on_main,
  output logic charge_en,
  output logic system_clock_on_internal,
  output logic clk_fail_irq,
  output logic slow_clock_output
);

  // two-stage release of the asynchronous reset
  logic rst_s1_ff;
  logic rst_s2_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  // every other process is reset by this released copy, not the pin
  wire logic srst_n = rst_s2_ff;

  // software registers
  logic [8:0] mode_ctrl_ff;
  logic [31:0] clk_gate_ff;
  logic [31:0] pull_ff;
  logic wake_pol_ff;
  logic [1:0] mon_ctrl_ff;
  logic fast_fail_ff;
  logic slow_fail_ff;
  logic [7:0] wake_flags_ff;
  power_state_t state_ff;
  power_state_t nxt_state;

  // address decode
  wire logic wr_mode = reg_wr && reg_addr == `REG_MODE_CTRL;
  wire logic wr_gate = reg_wr && reg_addr == `REG_CLK_GATE;
  wire logic wr_pull = reg_wr && reg_addr == `REG_STANDBY_PULL;
  wire logic wr_wake = reg_wr && reg_addr == `REG_WAKE_CFG;
  wire logic wr_mon = reg_wr && reg_addr == `REG_CLK_MON;
  wire logic wr_flags = reg_wr && reg_addr == `REG_WAKE_FLAGS;

  // field views
  wire logic [2:0] mode_sel = mode_ctrl_ff[`MODE_SEL_HI:`MODE_SEL_LO];
  wire logic retain_req = mode_ctrl_ff[`SRAM_RETAIN_BIT];
  wire logic cal_keep = mode_ctrl_ff[`CAL_KEEP_BIT];
  wire logic lp_run_req = mode_ctrl_ff[`LP_RUN_BIT];
  wire logic charge_req = mode_ctrl_ff[`CHARGE_EN_BIT];
  wire logic slow_out_req = mode_ctrl_ff[`SLOW_OUT_EN_BIT];
  // monitor and gate bits by name
  wire logic mon_en = mon_ctrl_ff[`MON_EN_BIT];
  wire logic mon_irq_en = mon_ctrl_ff[`MON_IRQ_EN_BIT];
  wire logic gate_core = clk_gate_ff[`GATE_CORE_BIT];
  wire logic gate_mem = clk_gate_ff[`GATE_MEM_BIT];

  // battery-only operation: main supply invalid while the battery is valid
  // in that state interrupts and calendar events cannot end a mode
  wire logic batt_only = !main_supply_valid && battery_valid;

  // wake pin edge of selectable polarity
  logic wake_pin_ff;
  wire logic wake_pin_edge = wake_pol_ff ?
    (wake_pin_ff && !wake_src.wakeup_pin) :
    (!wake_pin_ff && wake_src.wakeup_pin);

  // calendar events are only heard with the calendar keep bit set and outside battery-only operation
  wire logic cal_evt = !batt_only && cal_keep && (wake_src.cal_alarm ||
    wake_src.cal_periodic || wake_src.cal_timestamp ||
    wake_src.cal_tamper);
  wire logic irq_evt = !batt_only && wake_src.periph_irq;

  // exit causes per mode
  wire logic hard_exit = wake_src.ext_reset || wake_src.watchdog_reset ||
    wake_pin_edge || cal_evt;
  wire logic standby_exit = hard_exit || slow_xtal_fail;
  wire logic shutdown_exit = hard_exit;
  wire logic stop_exit = irq_evt || hard_exit;

  // mode transitions
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (wait_instr) begin
          // unused select codes fall back to plain sleep
          unique case (mode_sel)
            `SEL_STOP0: nxt_state = ST_STOP0;
            `SEL_STOP1: nxt_state = ST_STOP1;
            `SEL_STANDBY: nxt_state = ST_STANDBY;
            `SEL_SHUTDOWN: nxt_state = ST_SHUTDOWN;
            default: nxt_state = ST_SLEEP;
          endcase
        end else if (lp_run_req) begin
          nxt_state = ST_LP_RUN;
        end
      end
      ST_SLEEP: if (irq_evt || hard_exit) nxt_state = ST_RUN;
      ST_LP_RUN: begin
        if (wait_instr && mode_sel == `SEL_SLEEP) begin
          nxt_state = ST_LP_SLEEP;
        end else if (wait_instr) begin
          unique case (mode_sel)
            `SEL_STOP0: nxt_state = ST_STOP0;
            `SEL_STOP1: nxt_state = ST_STOP1;
            `SEL_STANDBY: nxt_state = ST_STANDBY;
            default: nxt_state = ST_SHUTDOWN;
          endcase
        end else if (!lp_run_req) begin
          nxt_state = ST_RUN;
        end
      end
      ST_LP_SLEEP: if (irq_evt || hard_exit) nxt_state = ST_LP_RUN;
      ST_STOP0: if (stop_exit) nxt_state = ST_RUN;
      ST_STOP1: if (stop_exit) nxt_state = ST_RUN;
      ST_STANDBY: if (standby_exit) nxt_state = ST_RUN;
      ST_SHUTDOWN: if (shutdown_exit) nxt_state = ST_RUN;
      default: nxt_state = ST_RUN;
    endcase
  end

  // leaving standby or shutdown is a reset of the core domain
  wire logic deep_exit = (state_ff == ST_STANDBY && standby_exit) ||
    (state_ff == ST_SHUTDOWN && shutdown_exit);
  wire logic deep_entry = nxt_state == ST_STANDBY ||
    nxt_state == ST_SHUTDOWN;

  // state register, run after reset
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) state_ff <= ST_RUN;
    else state_ff <= nxt_state;
  end

  // mode register: cleared on standby or shutdown exit, retain and calendar keep bits kept
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) mode_ctrl_ff <= `MODE_CTRL_RST;
    else if (deep_exit) mode_ctrl_ff <= mode_ctrl_ff & `DEEP_KEEP_MASK;
    else if (wr_mode) mode_ctrl_ff <= reg_wdata[8:0];
  end

  // clock gates and pad pulls
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      clk_gate_ff <= `CLK_GATE_RST;
      pull_ff <= `PULL_RST;
      wake_pol_ff <= 1'b0;
      mon_ctrl_ff <= 2'h0;
    end else if (deep_exit) begin
      clk_gate_ff <= `CLK_GATE_RST;
      mon_ctrl_ff <= 2'h0;
    end else begin
      if (wr_gate) clk_gate_ff <= reg_wdata;
      if (wr_pull) pull_ff <= reg_wdata;
      if (wr_wake) wake_pol_ff <= reg_wdata[`WAKE_POL_BIT];
      if (wr_mon) mon_ctrl_ff <= reg_wdata[`MON_IRQ_EN_BIT:`MON_EN_BIT];
    end
  end

  // clock failure flags: set wins over a write-one clear
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      fast_fail_ff <= 1'b0;
      slow_fail_ff <= 1'b0;
    end else begin
      fast_fail_ff <= (mon_en && fast_xtal_fail) || (fast_fail_ff &&
        !(wr_mon && reg_wdata[`MON_FAST_FAIL_BIT]));
      slow_fail_ff <= (mon_en && slow_xtal_fail) || (slow_fail_ff &&
        !(wr_mon && reg_wdata[`MON_SLOW_FAIL_BIT]));
    end
  end

  // wake cause flags, write-one to clear, set wins
  // flags latch only while asleep, so run-time events never look like wakes
  wire logic [7:0] wake_now = {slow_xtal_fail, wake_src.cal_tamper |
    wake_src.cal_timestamp, wake_src.cal_periodic, wake_src.cal_alarm,
    wake_pin_edge, wake_src.watchdog_reset, wake_src.ext_reset, irq_evt};
  wire logic [7:0] wake_set = (state_ff == ST_RUN || state_ff == ST_LP_RUN) ?
    8'h00 : wake_now;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) wake_flags_ff <= 8'h00;
    else wake_flags_ff <= wake_set |
      (wake_flags_ff & ~(wr_flags ? reg_wdata[7:0] : 8'h00));
  end

  // wake pin history
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) wake_pin_ff <= 1'b0;
    else wake_pin_ff <= wake_src.wakeup_pin;
  end

  // processor clock divider for low-power run
  // free running: the first pulse after entry may come early, the rate holds
  logic [7:0] div_ff;
  wire logic div_tick = div_ff == `LP_DIV_COUNT - 8'h01;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) div_ff <= 8'h00;
    else div_ff <= div_tick ? 8'h00 : div_ff + 8'h01;
  end

  // reset window for pads: held low until the release settles
  // an internal reset or a deep exit reopens the window
  logic in_reset_ff;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) in_reset_ff <= 1'b1;
    else in_reset_ff <= deep_exit || internal_reset;
  end

  // state decodes
  wire logic st_stop = state_ff == ST_STOP0 || state_ff == ST_STOP1;
  wire logic st_deep = state_ff == ST_STANDBY || state_ff == ST_SHUTDOWN;
  wire logic st_lp = state_ff != ST_RUN;
  // core domain clocked: neither stop nor deep
  wire logic st_active = !st_stop && !st_deep;

  // power control for the current state, registered below
  power_ctrl_t nxt_pwr;
  always_comb begin
    nxt_pwr = '0;
    nxt_pwr.main_regulator_on = state_ff == ST_RUN ||
      state_ff == ST_SLEEP || state_ff == ST_STOP0;
    nxt_pwr.low_power_regulator_on = state_ff == ST_LP_RUN ||
      state_ff == ST_LP_SLEEP || st_stop ||
      (state_ff == ST_STANDBY && retain_req);
    nxt_pwr.lpr_sram_only = state_ff == ST_STANDBY && retain_req;
    nxt_pwr.pll_on = st_active;
    nxt_pwr.internal_fast_oscillator_on = st_active ||
      (st_stop && periph_fast_osc_req);
    nxt_pwr.external_fast_oscillator_on = st_active &&
      !fast_fail_ff;
    nxt_pwr.internal_slow_oscillator_on = state_ff != ST_SHUTDOWN;
    nxt_pwr.external_slow_oscillator_on = 1'b1;
    nxt_pwr.supply_on_off_reset_on = state_ff != ST_SHUTDOWN;
    nxt_pwr.brownout_detection_on = state_ff != ST_SHUTDOWN;
  end

  // registered outputs
  // every output is registered from the previous cycle's state and inputs, so they all move together
  // and no pin glitches while the next state settles
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      power_ctrl <= '0;
      mode_onehot <= 8'h01;
      cpu_clk_en <= 1'b0;
      cpu_clk_slow_en <= 1'b0;
      core_clk_en <= 1'b0;
      periph_clk_en <= 32'h0;
      mem_clk_en <= 1'b0;
      sram_retain <= 1'b0;
      regs_lost <= 1'b0;
      pad_pull_up <= 32'h0;
      pad_pull_down <= 32'h0;
      schmitt_en <= 1'b0;
      reset_pullup_en <= 1'b1;
      backup_on_main <= 1'b0;
      charge_en <= 1'b0;
      system_clock_on_internal <= 1'b0;
      clk_fail_irq <= 1'b0;
      slow_clock_output <= 1'b0;
    end else begin
      power_ctrl <= nxt_pwr;
      mode_onehot <= state_ff;
      cpu_clk_en <= (state_ff == ST_RUN) ||
        (state_ff == ST_LP_RUN && div_tick);
      cpu_clk_slow_en <= state_ff == ST_LP_RUN;
      core_clk_en <= st_active && gate_core;
      periph_clk_en <= (st_stop || st_deep) ? 32'h0 :
        {clk_gate_ff[31:2], 2'b00};
      mem_clk_en <= st_active && gate_mem;
      sram_retain <= !st_deep || (state_ff == ST_STANDBY && retain_req);
      regs_lost <= st_deep;
      pad_pull_up <= state_ff == ST_STANDBY ? pull_ff : 32'h0;
      pad_pull_down <= state_ff == ST_STANDBY ? ~pull_ff : 32'h0;
      schmitt_en <= !in_reset_ff && !deep_exit;
      reset_pullup_en <= !internal_reset;
      backup_on_main <= main_supply_valid;
      charge_en <= main_supply_valid && charge_req;
      system_clock_on_internal <= fast_fail_ff;
      clk_fail_irq <= mon_irq_en && (fast_fail_ff || slow_fail_ff);
      slow_clock_output <= st_lp && !batt_only &&
        slow_out_req && slow_clk_in;
    end
  end

  // read mux, data stand one cycle after the strobe
  // unmapped indices read zero; status is read only
  logic [31:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      `REG_MODE_CTRL: rd_mux = {23'h0, mode_ctrl_ff};
      `REG_CLK_GATE: rd_mux = clk_gate_ff;
      `REG_STANDBY_PULL: rd_mux = pull_ff;
      `REG_WAKE_CFG: rd_mux = {31'h0, wake_pol_ff};
      `REG_CLK_MON: rd_mux = {28'h0, slow_fail_ff, fast_fail_ff, mon_ctrl_ff};
      `REG_STATUS: rd_mux = {22'h0, batt_only, main_supply_valid, state_ff};
      `REG_WAKE_FLAGS: rd_mux = {24'h0, wake_flags_ff};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) reg_rdata <= 32'h0;
    else reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

endmodule

/* File: bench/low_power_mode_props.sv */
// assertions on the ports of the low-power mode controller
// assumes one clock domain; bound onto the controller below
`timescale 1ns/100ps
module low_power_mode_props
  import power_mode_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // inputs seen by the controller
  input wire logic wait_instr,
  input wire logic internal_reset,
  input wire logic periph_fast_osc_req,
  input wire wake_src_t wake_src,
  input wire logic main_supply_valid,
  // outputs watched
  input wire power_ctrl_t power_ctrl,
  input wire logic [7:0] mode_onehot,
  input wire logic cpu_clk_en,
  input wire logic core_clk_en,
  input wire logic reset_pullup_en,
  input wire logic backup_on_main,
  input wire logic charge_en
);
  logic [2:0] up_ff;
  logic up, stop, deep;
  power_ctrl_t pc;

  // edges since release; outputs have settled once up is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_ff <= 3'h0;
    else if (!up) up_ff <= up_ff + 3'h1;
  end

  // mode groups
  assign up = up_ff == 3'h5;
  assign stop = mode_onehot inside {ST_STOP0, ST_STOP1};
  assign deep = mode_onehot inside {ST_STANDBY, ST_SHUTDOWN};
  assign pc = power_ctrl;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_main_reg_on: assert property (
    up && mode_onehot inside {ST_RUN, ST_SLEEP} |-> pc.main_regulator_on)
    else $error("main regulator off in run or sleep");
  a_lp_regulator: assert property (
    up && mode_onehot inside {ST_LP_RUN, ST_LP_SLEEP}
    |-> pc.low_power_regulator_on && !pc.main_regulator_on)
    else $error("wrong regulator in low-power run or sleep");
  a_stop_clocks: assert property (
    up && stop |-> !core_clk_en && !pc.pll_on &&
    !pc.external_fast_oscillator_on &&
    pc.main_regulator_on == (mode_onehot == ST_STOP0))
    else $error("stop mode clocks or regulator wrong");
  a_stop_fast_req: assert property (
    up && stop && periph_fast_osc_req ##1 stop
    |-> ##[0:1] pc.internal_fast_oscillator_on)
    else $error("fast oscillator request ignored in stop");
  a_deep_power: assert property (
    up && deep |-> !pc.main_regulator_on && !pc.pll_on &&
    !pc.internal_fast_oscillator_on && !pc.external_fast_oscillator_on &&
    (!pc.low_power_regulator_on || pc.lpr_sram_only))
    else $error("deep mode power enables wrong");
  a_shutdown_off: assert property (
    up && deep |-> pc.supply_on_off_reset_on == (mode_onehot == ST_STANDBY)
    && (mode_onehot == ST_STANDBY || !pc.low_power_regulator_on &&
    !pc.brownout_detection_on && !pc.internal_slow_oscillator_on))
    else $error("supervisor or slow oscillator wrong in deep mode");
  a_run_entry: assert property (
    up && mode_onehot == ST_RUN ##1 mode_onehot inside {ST_SLEEP,
    ST_STOP0, ST_STOP1, ST_STANDBY, ST_SHUTDOWN} |-> $past(wait_instr, 2))
    else $error("low-power mode entered without wait");
  a_sleep_wake: assert property (
    up && mode_onehot == ST_SLEEP && wake_src.periph_irq
    |-> ##[1:3] mode_onehot == ST_RUN)
    else $error("interrupt did not wake sleep");
  a_lp_sleep_wake: assert property (
    up && mode_onehot == ST_LP_SLEEP && wake_src.periph_irq
    |-> ##[1:3] mode_onehot == ST_LP_RUN)
    else $error("low-power sleep did not return to low-power run");
  a_lp_cpu_slow: assert property (
    up && mode_onehot == ST_LP_RUN && cpu_clk_en
    |=> (!cpu_clk_en || mode_onehot != ST_LP_RUN)[*8])
    else $error("processor clock too fast in low-power run");
  a_charge_gate: assert property (
    up && charge_en |-> $past(main_supply_valid))
    else $error("charging without valid main supply");
  a_backup_main: assert property (
    up && main_supply_valid && $past(main_supply_valid) |-> backup_on_main)
    else $error("backup domain not on main supply");
  a_pullup_drop: assert property (
    internal_reset[*2] |-> !reset_pullup_en)
    else $error("reset pull-up kept during internal reset");

  // main scenarios reached
  c_sleep_wake: cover property (mode_onehot == ST_SLEEP ##1
    mode_onehot == ST_RUN);
  c_retain: cover property (up && pc.lpr_sram_only);
  c_lp_pulse: cover property (mode_onehot == ST_LP_RUN && cpu_clk_en);
endmodule

bind low_power_mode_controller low_power_mode_props i_low_power_mode_props (
  .clk, .rst_n, .wait_instr, .internal_reset, .periph_fast_osc_req,
  .wake_src, .main_supply_valid, .power_ctrl, .mode_onehot, .cpu_clk_en,
  .core_clk_en, .reset_pullup_en, .backup_on_main, .charge_en
);

/* File: bench/tb_top.sv */
// self-checking bench for the low-power mode controller
// assumes the map header is in the include path and the checker is bound
`timescale 1ns/100ps
`include "power_mode_map.svh"
module tb_top;
  import power_mode_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic wait_instr = 1'b0;
  logic internal_reset = 1'b0;
  logic periph_fast_osc_req = 1'b0;
  wake_src_t wake_src = 8'h00;
  logic main_supply_valid = 1'b1;
  logic battery_valid = 1'b1;
  logic fast_xtal_fail = 1'b0;
  logic slow_xtal_fail = 1'b0;
  logic slow_clk_in = 1'b0;
  power_ctrl_t pc;
  logic [7:0] mode_onehot;
  logic [31:0] reg_rdata, periph_clk_en, pad_pull_up, pad_pull_down;
  logic cpu_clk_en, cpu_clk_slow_en, core_clk_en, mem_clk_en, sram_retain;
  logic regs_lost, schmitt_en, reset_pullup_en, backup_on_main, charge_en;
  logic system_clock_on_internal, clk_fail_irq, slow_clock_output;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  low_power_mode_controller i_low_power_mode_controller (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .wait_instr, .internal_reset, .periph_fast_osc_req, .wake_src,
    .main_supply_valid, .battery_valid, .fast_xtal_fail, .slow_xtal_fail,
    .slow_clk_in, .power_ctrl(pc), .mode_onehot, .cpu_clk_en,
    .cpu_clk_slow_en, .core_clk_en, .periph_clk_en, .mem_clk_en,
    .sram_retain, .regs_lost, .pad_pull_up, .pad_pull_down, .schmitt_en,
    .reset_pullup_en, .backup_on_main, .charge_en, .system_clock_on_internal,
    .clk_fail_irq, .slow_clock_output
  );

  // clock, slow oscillator stand-in and hang limit
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    slow_clk_in <= cyc[3];
    if (cyc == 20000) begin
      n_errors++;
      results;
    end
  end

  task results;
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one-cycle register strobes
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task pulse_wait;
    @(posedge clk);
    wait_instr <= 1'b1;
    @(posedge clk);
    wait_instr <= 1'b0;
  endtask

  // wake source held three cycles
  task kick(input wake_src_t w);
    @(posedge clk);
    wake_src <= w;
    repeat (3) @(posedge clk);
    wake_src <= 8'h00;
  endtask

  task wait_mode(input logic [7:0] m);
    for (int k = 0; k < 40 && mode_onehot !== m; k++) begin
      @(posedge clk);
      #1;
    end
    chk(32'(mode_onehot), 32'(m));
  endtask

  // does the slow clock output move at all over 40 cycles
  task toggles(input logic exp);
    int n;
    logic last;
    n = 0;
    last = slow_clock_output;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (slow_clock_output !== last) n++;
      last = slow_clock_output;
    end
    chk(32'(n > 0), 32'(exp));
  endtask

  task t_reset;
    chk(32'(mode_onehot), 32'(ST_RUN));
    chk(32'({pc.main_regulator_on, core_clk_en}), 32'h3);
    rd(`REG_MODE_CTRL, 32'(`MODE_CTRL_RST));
    rd(`REG_STANDBY_PULL, `PULL_RST);
    rd(`REG_STATUS, 32'h101);
    rd(4'hf, 32'h0);
  endtask

  task t_gate;
    wr(`REG_CLK_GATE, 32'h00000005);
    idle(2);
    chk(32'({core_clk_en, mem_clk_en}), 32'h2);
    chk(periph_clk_en, 32'h00000004);
    rd(`REG_CLK_GATE, 32'h00000005);
    wr(`REG_CLK_GATE, `CLK_GATE_RST);
  endtask

  task t_sleep;
    wr(`REG_MODE_CTRL, 32'(`SEL_STOP0));
    idle(5);
    chk(32'(mode_onehot), 32'(ST_RUN));
    wr(`REG_MODE_CTRL, 32'(`SEL_SLEEP));
    pulse_wait;
    wait_mode(ST_SLEEP);
    chk(32'({cpu_clk_en, core_clk_en}), 32'h1);
    chk(periph_clk_en, 32'hfffffffc);
    kick(wake_src_t'(8'h01));
    wait_mode(ST_RUN);
  endtask

  task t_stop;
    for (int i = 0; i < 2; i++) begin
      wr(`REG_MODE_CTRL, 32'h80 | 32'(i + 1));
      pulse_wait;
      wait_mode(i ? ST_STOP1 : ST_STOP0);
      chk(32'({pc.main_regulator_on, pc.pll_on}), i ? 32'h0 : 32'h2);
      toggles(1'b1);
      @(posedge clk);
      periph_fast_osc_req <= 1'b1;
      idle(3);
      chk(32'(pc.internal_fast_oscillator_on), 32'h1);
      @(posedge clk);
      periph_fast_osc_req <= 1'b0;
      kick(wake_src_t'(8'h01));
      wait_mode(ST_RUN);
      rd(`REG_MODE_CTRL, 32'h80 | 32'(i + 1));
    end
  endtask

  task t_lp;
    int n;
    wr(`REG_MODE_CTRL, 32'h20);
    wait_mode(ST_LP_RUN);
    chk(32'({pc.main_regulator_on, pc.low_power_regulator_on}), 32'h1);
    chk(32'(cpu_clk_slow_en), 32'h1);
    n = 0;
    repeat (250) begin
      @(posedge clk);
      #1;
      n += cpu_clk_en;
    end
    chk(32'(n), 32'h2);
    pulse_wait;
    wait_mode(ST_LP_SLEEP);
    kick(wake_src_t'(8'h01));
    wait_mode(ST_LP_RUN);
    wr(`REG_MODE_CTRL, 32'h0);
    wait_mode(ST_RUN);
  endtask

  // every wake source tried in turn; the processor interrupt must not exit
  task t_deep(input logic [2:0] sel, input logic [7:0] st,
    input logic [6:0] pw, input logic pol);
    for (int i = 0; i < 8; i++) begin
      wr(`REG_WAKE_FLAGS, 32'hff);
      wr(`REG_WAKE_CFG, 32'(pol));
      wr(`REG_STANDBY_PULL, 32'h0000a5a5);
      wr(`REG_MODE_CTRL, 32'h18 | 32'(sel));
      pulse_wait;
      wait_mode(st);
      chk(32'({pc.main_regulator_on, pc.low_power_regulator_on,
        pc.lpr_sram_only, pc.supply_on_off_reset_on, pc.pll_on,
        pc.internal_fast_oscillator_on, pc.external_fast_oscillator_on}),
        32'(pw));
      if (sel == `SEL_STANDBY) begin
        chk(pad_pull_up, 32'h0000a5a5);
        chk(pad_pull_down, 32'hffff5a5a);
        chk(32'({sram_retain, regs_lost}), 32'h3);
      end
      kick(wake_src_t'(8'h01 << i));
      if (i == 0) begin
        #1 chk(32'(mode_onehot), 32'(st));
        kick(wake_src_t'(8'h80));
      end
      wait_mode(ST_RUN);
      rd(`REG_MODE_CTRL, 32'h18);
      if (sel == `SEL_STANDBY && i == 5) rd(`REG_WAKE_FLAGS, 32'h8);
    end
  endtask

  task t_clk;
    wr(`REG_CLK_MON, 32'h3);
    @(posedge clk);
    fast_xtal_fail <= 1'b1;
    idle(3);
    chk(32'({system_clock_on_internal, clk_fail_irq}), 32'h3);
    @(posedge clk);
    fast_xtal_fail <= 1'b0;
    slow_xtal_fail <= 1'b1;
    rd(`REG_CLK_MON, 32'hf);
    @(posedge clk);
    slow_xtal_fail <= 1'b0;
    wr(`REG_CLK_MON, 32'hf);
    rd(`REG_CLK_MON, 32'h3);
    chk(32'(clk_fail_irq), 32'h0);
    wr(`REG_MODE_CTRL, 32'(`SEL_STANDBY));
    pulse_wait;
    wait_mode(ST_STANDBY);
    @(posedge clk);
    slow_xtal_fail <= 1'b1;
    wait_mode(ST_RUN);
    @(posedge clk);
    slow_xtal_fail <= 1'b0;
  endtask

  task t_batt;
    wr(`REG_MODE_CTRL, 32'h40);
    idle(2);
    chk(32'({charge_en, backup_on_main}), 32'h3);
    wr(`REG_MODE_CTRL, 32'hd3);
    pulse_wait;
    wait_mode(ST_STANDBY);
    @(posedge clk);
    main_supply_valid <= 1'b0;
    idle(3);
    chk(32'({charge_en, backup_on_main}), 32'h0);
    toggles(1'b0);
    kick(wake_src_t'(8'h10));
    #1 chk(32'(mode_onehot), 32'(ST_STANDBY));
    @(posedge clk);
    main_supply_valid <= 1'b1;
    kick(wake_src_t'(8'h80));
    wait_mode(ST_RUN);
    chk(32'(backup_on_main), 32'h1);
  endtask

  task t_intrst;
    @(posedge clk);
    internal_reset <= 1'b1;
    idle(3);
    chk(32'({schmitt_en, reset_pullup_en}), 32'h0);
    @(posedge clk);
    internal_reset <= 1'b0;
    idle(4);
    chk(32'(mode_onehot), 32'(ST_RUN));
  endtask

  // reset, then each scenario in turn
  initial begin
    repeat (16) @(posedge clk);
    chk(32'({schmitt_en, reset_pullup_en}), 32'h1);
    rst_n <= 1'b1;
    idle(4);
    t_reset;
    t_gate;
    t_sleep;
    t_stop;
    t_lp;
    t_deep(`SEL_STANDBY, ST_STANDBY, 7'h38, 1'b0);
    t_deep(`SEL_SHUTDOWN, ST_SHUTDOWN, 7'h00, 1'b1);
    t_clk;
    t_batt;
    t_intrst;
    results;
  end
endmodule
